/* hdl/bit_sync.v */
`timescale 1ns/1ps
`include "i2c_slave_consts.vh"

module bit_sync (
	input wire mclk_i,
	input wire rst_n_i,
	input wire [`SYNC_W-1:0] d_i,
	output reg [`SYNC_W-1:0] q_o
);

	reg [`SYNC_W-1:0] meta_reg;

	// Lines idle high, so reset to ones to avoid a false start at release
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_reg <= `SYNC_RESET;
			q_o <= `SYNC_RESET;
		end else begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end

endmodule // bit_sync

/* hdl/i2c_slave_consts.vh */
`ifndef I2C_SLAVE_CONSTS_VH
`define I2C_SLAVE_CONSTS_VH

// Bits per byte on the wire, acknowledge excluded
`define BYTE_BITS 4'h8
`define BIT_CNT_ZERO 4'h0
`define BIT_CNT_STEP 4'h1

// Pointer ring that steps and wraps; everything else holds
`define PTR_RING_LO 8'h10
`define PTR_RING_HI 8'h13
`define PTR_STEP 8'h01
`define PTR_RESET 8'h00

`define BYTE_RESET 8'h00
`define ADDR_RESET 7'h00

// Select pin classes: bit 1 set means tied to a bus line, bit 0 set means supply or data line
`define STRAP_GND 2'h0
`define STRAP_VPLUS 2'h1
`define STRAP_SCL 2'h2
`define STRAP_SDA 2'h3

// Samples start as all ones: classes other than ground read as supply until a frame is seen; idle samples show ground at once
`define STRAP_SMP_RESET 3'h7

// Synchroniser lanes: scl, sda, three select pins
`define SYNC_W 5
`define SYNC_RESET 5'h1f
`define LANE_SCL 4
`define LANE_SDA 3

`endif

/* hdl/i2c_strap_slave.v */
`timescale 1ns/1ps
`include "i2c_slave_consts.vh"

// Operation
// - Both lines are released high by everyone while no transfer runs.
// - Falling data while clock high is START; device begins a transaction.
// - Rising data while clock high is STOP; bus becomes free.
// - One bit per clock pulse; data steady while clock is high.
// - Ninth clock per byte carries acknowledge, receiver holds data low.
// - Device acknowledges every byte it receives in a frame addressed to it.
// - First byte is seven address bits plus direction, low means write.
// - Each select pin is classed ground, supply, data line or clock line.
// - Select pin combinations give 64 distinct addresses.
// - Address bits 6..4 come from select pins 2 and 1.
// - Bit 3 from pin 0 on bus line; bits 2..0 from supply or data.
// - Transaction: START, address, pointer byte, data bytes, STOP.
// - Write carries zero direction bit, then command byte first.
// - Stored command byte selects the register for the next data byte.
// - STOP right after command byte only keeps the pointer.
// - Bytes after command are data; first goes to selected register.
// - Pointer advances after each data byte before STOP.
// - Data line is input and open-drain output, only ever pulled low.
// - Pointer holds for single registers, cycles 0x10 to 0x13 and wraps.
// - Reads use the same pointer and advance by the same steps.
module i2c_strap_slave (
	input wire mclk_i,
	input wire nrst_i,
	input wire scl_i,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_o,
	input wire addr_select_pin_0_i,
	input wire addr_select_pin_1_i,
	input wire addr_select_pin_2_i,
	output reg wr_en_o,
	output reg [7:0] wr_addr_o,
	output reg [7:0] wr_data_o,
	output reg [7:0] rd_addr_o,
	input wire [7:0] rd_data_i,
	output reg rd_done_o,
	output reg busy_o,
	output reg [6:0] dev_addr_o
);

	localparam ST_IDLE = 4'h0;
	localparam ST_ADDR = 4'h1;
	localparam ST_ACK = 4'h2;
	localparam ST_CMD = 4'h3;
	localparam ST_WDATA = 4'h4;
	localparam ST_RDATA = 4'h5;
	localparam ST_MACK = 4'h6;
	localparam ST_IGNORE = 4'h7;

	reg [1:0] rst_pipe_reg;
	wire rst_n;
	wire [`SYNC_W-1:0] lines_s;
	wire scl_s;
	wire sda_s;
	reg scl_prev_reg;
	reg sda_prev_reg;
	wire start_det;
	wire stop_det;
	wire scl_rise;
	wire scl_fall;
	wire [6:0] strap_addr;

	reg [3:0] state_reg;
	reg [3:0] state_next;
	reg [3:0] ack_next_reg;
	reg [3:0] bit_cnt_reg;
	reg [7:0] shift_reg;
	reg [7:0] ptr_reg;
	wire byte_done;
	wire addr_hit;
	wire wbyte_take;
	wire rbyte_take;

	// Step within the intensity ring, hold elsewhere
	function [7:0] next_ptr;
		input [7:0] p;
		begin
			if (p == `PTR_RING_HI)
				next_ptr = `PTR_RING_LO;
			else if ((p >= `PTR_RING_LO) && (p < `PTR_RING_HI))
				next_ptr = p + `PTR_STEP;
			else
				next_ptr = p;
		end
	endfunction

	// Address byte carries the target address above the direction bit
	function addr_match;
		input [7:0] b;
		input [6:0] a;
		begin
			addr_match = (b[7:1] == a);
		end
	endfunction

	// Open drain: a zero bit means pull, a one bit means let go
	function pull_for_bit;
		input b;
		begin
			pull_for_bit = ~b;
		end
	endfunction

	function [3:0] count_up;
		input [3:0] c;
		begin
			count_up = c + `BIT_CNT_STEP;
		end
	endfunction

	// Reset asserts at once, releases through two flops
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			rst_pipe_reg <= 2'h0;
		else
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
	end
	assign rst_n = rst_pipe_reg[1];

	// Select pins pass the same two flops as the bus lines, so all
	// lanes stay aligned when the classifier compares them
	bit_sync u_sync (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n),
		.d_i({scl_i, sda_i, addr_select_pin_2_i, addr_select_pin_1_i, addr_select_pin_0_i}),
		.q_o(lines_s)
	);

	assign scl_s = lines_s[`LANE_SCL];
	assign sda_s = lines_s[`LANE_SDA];

	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
		end
	end

	assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
	assign stop_det = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
	assign scl_rise = scl_s && !scl_prev_reg;
	assign scl_fall = !scl_s && scl_prev_reg;
	assign byte_done = (bit_cnt_reg == `BYTE_BITS);
	assign addr_hit = addr_match(shift_reg, strap_addr);
	// Strobes use the same gating as the state process so they cannot drift apart
	assign wbyte_take = !stop_det && !start_det && (state_reg == ST_WDATA) &&
		scl_fall && byte_done;
	// Read done and pointer step on every ninth rise, acknowledged or not
	assign rbyte_take = !stop_det && !start_det && (state_reg == ST_MACK) && scl_rise;

	// Classes settle from the idle, START and first-fall samples of each frame

	strap_classifier u_strap (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n),
		.scl_i(scl_s),
		.sda_i(sda_s),
		.pins_i(lines_s[2:0]),
		.start_i(start_det),
		.scl_fall_i(scl_fall),
		.dev_addr_o(strap_addr)
	);

	always @* begin
		state_next = state_reg;
		if (stop_det) begin
			state_next = ST_IDLE;
		end else if (start_det) begin
			state_next = ST_ADDR;
		end else begin
			case (state_reg)
				ST_ADDR: begin
					if (scl_fall && byte_done) begin
						if (addr_hit)
							state_next = ST_ACK;
						else
							state_next = ST_IGNORE;
					end
				end
				ST_CMD, ST_WDATA: begin
					if (scl_fall && byte_done)
						state_next = ST_ACK;
				end
				ST_ACK: begin
					if (scl_fall)
						state_next = ack_next_reg;
				end
				ST_RDATA: begin
					if (scl_fall && byte_done)
						state_next = ST_MACK;
				end
				ST_MACK: begin
					if (scl_rise && sda_s)
						state_next = ST_IGNORE;
					else if (scl_fall)
						state_next = ST_RDATA;
				end
				ST_IDLE, ST_IGNORE: begin
					state_next = state_reg;
				end
				default: begin
					state_next = ST_IDLE;
				end
			endcase
		end
	end

	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			ack_next_reg <= ST_CMD;
			bit_cnt_reg <= `BIT_CNT_ZERO;
			shift_reg <= `BYTE_RESET;
			ptr_reg <= `PTR_RESET;
			sda_oe_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (stop_det) begin
				sda_oe_o <= 1'b0;
				bit_cnt_reg <= `BIT_CNT_ZERO;
			end else if (start_det) begin
				// Repeated start also lands here; the pointer survives it
				sda_oe_o <= 1'b0;
				bit_cnt_reg <= `BIT_CNT_ZERO;
			end else begin
				case (state_reg)
					ST_ADDR, ST_CMD, ST_WDATA: begin
						if (scl_rise && !byte_done) begin
							shift_reg <= {shift_reg[6:0], sda_s};
							bit_cnt_reg <= count_up(bit_cnt_reg);
						end
						if (scl_fall && byte_done) begin
							if (state_reg == ST_ADDR) begin
								if (addr_hit) begin
									sda_oe_o <= 1'b1;
									ack_next_reg <= shift_reg[0] ? ST_RDATA : ST_CMD;
								end
							end else if (state_reg == ST_CMD) begin
								sda_oe_o <= 1'b1;
								ptr_reg <= shift_reg;
								ack_next_reg <= ST_WDATA;
							end else begin
								// Strobe, address and data are registered in the strobe process
								sda_oe_o <= 1'b1;
								ptr_reg <= next_ptr(ptr_reg);
								ack_next_reg <= ST_WDATA;
							end
						end
					end
					ST_ACK: begin
						// Held low through the ninth high phase; on its fall let go, or drive bit 7 of the read byte
						if (scl_fall) begin
							bit_cnt_reg <= `BIT_CNT_ZERO;
							if (ack_next_reg == ST_RDATA) begin
								shift_reg <= rd_data_i;
								sda_oe_o <= pull_for_bit(rd_data_i[7]);
							end else begin
								sda_oe_o <= 1'b0;
							end
						end
					end
					ST_RDATA: begin
						if (scl_rise && !byte_done)
							bit_cnt_reg <= count_up(bit_cnt_reg);
						if (scl_fall) begin
							if (byte_done) begin
								sda_oe_o <= 1'b0;
							end else begin
								// Change data only with clock low
								shift_reg <= {shift_reg[6:0], 1'b0};
								sda_oe_o <= pull_for_bit(shift_reg[6]);
							end
						end
					end
					ST_MACK: begin
						if (scl_rise) begin
							ptr_reg <= next_ptr(ptr_reg);
						end
						if (scl_fall) begin
							bit_cnt_reg <= `BIT_CNT_ZERO;
							shift_reg <= rd_data_i;
							sda_oe_o <= pull_for_bit(rd_data_i[7]);
						end
					end
					ST_IDLE, ST_IGNORE: begin
						sda_oe_o <= 1'b0;
					end
					default: begin
						sda_oe_o <= 1'b0;
					end
				endcase
			end
		end
	end

	// Only ever pulls low; the high level comes from the pullup
	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n)
			sda_o <= 1'b0;
		else
			sda_o <= 1'b0;
	end

	// Strobes and status kept apart from the state process
	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			wr_en_o <= 1'b0;
			wr_addr_o <= `PTR_RESET;
			wr_data_o <= `BYTE_RESET;
			rd_done_o <= 1'b0;
		end else begin
			wr_en_o <= wbyte_take;
			rd_done_o <= rbyte_take;
			if (wbyte_take) begin
				wr_addr_o <= ptr_reg;
				wr_data_o <= shift_reg;
			end
		end
	end

	// Pointer copy lags the internal pointer by one cycle
	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			rd_addr_o <= `PTR_RESET;
			busy_o <= 1'b0;
			dev_addr_o <= `ADDR_RESET;
		end else begin
			rd_addr_o <= ptr_reg;
			busy_o <= (state_next != ST_IDLE);
			dev_addr_o <= strap_addr;
		end
	end

	// No clock output exists: the controller owns SCL and starts every frame

endmodule // i2c_strap_slave

/* hdl/strap_classifier.v */
`timescale 1ns/1ps
`include "i2c_slave_consts.vh"

module strap_classifier (
	input wire mclk_i,
	input wire rst_n_i,
	input wire scl_i,
	input wire sda_i,
	input wire [2:0] pins_i,
	input wire start_i,
	input wire scl_fall_i,
	output reg [6:0] dev_addr_o
);

	reg [2:0] idle_smp_reg;
	reg [2:0] start_smp_reg;
	reg [2:0] fall_smp_reg;
	reg armed_reg;
	wire [1:0] cls0;
	wire [1:0] cls1;
	wire [1:0] cls2;

	// Three bus states tell the four ties apart: idle (scl=1,sda=1),
	// start (scl=1,sda=0) and first scl fall after start (scl=0,sda=0)
	function [1:0] classify;
		input idle_v;
		input start_v;
		input fall_v;
		begin
			if (!idle_v)
				classify = `STRAP_GND;
			else if (!start_v)
				classify = `STRAP_SDA;
			else if (!fall_v)
				classify = `STRAP_SCL;
			else
				classify = `STRAP_VPLUS;
		end
	endfunction

	assign cls0 = classify(idle_smp_reg[0], start_smp_reg[0], fall_smp_reg[0]);
	assign cls1 = classify(idle_smp_reg[1], start_smp_reg[1], fall_smp_reg[1]);
	assign cls2 = classify(idle_smp_reg[2], start_smp_reg[2], fall_smp_reg[2]);

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idle_smp_reg <= `STRAP_SMP_RESET;
			start_smp_reg <= `STRAP_SMP_RESET;
			fall_smp_reg <= `STRAP_SMP_RESET;
			armed_reg <= 1'b0;
			dev_addr_o <= `ADDR_RESET;
		end else begin
			if (scl_i && sda_i)
				idle_smp_reg <= pins_i;
			if (start_i) begin
				start_smp_reg <= pins_i;
				armed_reg <= 1'b1;
			end else if (scl_fall_i && armed_reg) begin
				fall_smp_reg <= pins_i;
				armed_reg <= 1'b0;
			end
			dev_addr_o[6] <= cls2[1];
			dev_addr_o[5] <= ~cls1[1];
			dev_addr_o[4] <= cls1[1];
			dev_addr_o[3] <= cls0[1];
			dev_addr_o[2:0] <= {cls2[0], cls1[0], cls0[0]};
		end
	end

endmodule // strap_classifier

/* verif/bus_ctrl.sv */
`timescale 1ns/1ps
module bus_ctrl (
	input wire clk_i,
	input wire sda_i,
	output reg scl_o,
	output reg pull_o
);
	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end
	task wt(input integer n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// Entered with clock low; data moves one cycle after the fall for hold
	task bt(input v, output s);
		wt(1);
		pull_o = !v;
		wt(3);
		scl_o = 1'b1;
		wt(2);
		s = sda_i;
		wt(2);
		scl_o = 1'b0;
	endtask
	task start;
		wt(1);
		pull_o = 1'b0;
		wt(3);
		scl_o = 1'b1;
		wt(4);
		pull_o = 1'b1;
		wt(4);
		scl_o = 1'b0;
	endtask
	task stop;
		wt(1);
		pull_o = 1'b1;
		wt(3);
		scl_o = 1'b1;
		wt(4);
		pull_o = 1'b0;
		wt(4);
	endtask
	task wb(input [7:0] b, output ack);
		integer i;
		reg s;
		for (i = 7; i >= 0; i = i - 1) bt(b[i], s);
		bt(1'b1, s);
		ack = !s;
	endtask
	task rb(input last, output [7:0] d);
		integer i;
		reg s;
		for (i = 0; i < 8; i = i + 1) begin
			bt(1'b1, s);
			d = {d[6:0], s};
		end
		bt(last, s);
	endtask
endmodule // bus_ctrl

/* verif/slave_monitor.sv */
`timescale 1ns/1ps
module slave_monitor (
	input wire mclk_i,
	input wire nrst_i,
	input wire scl_i,
	input wire sda_i,
	input wire sda_o,
	input wire sda_oe_o,
	input wire wr_en_o,
	input wire [7:0] wr_addr_o,
	input wire [7:0] rd_addr_o,
	input wire rd_done_o,
	input wire busy_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	chk_drive_low: assert property (sda_oe_o |-> !sda_o)
		else $error("data line driven high");
	chk_idle_free: assert property (!busy_o |-> !sda_oe_o)
		else $error("data pulled while idle");
	chk_hold_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
		else $error("data moved while clock high");
	chk_start_busy: assert property (scl_i && $fell(sda_i) |-> ##[1:6] busy_o)
		else $error("start not seen");
	chk_stop_free: assert property (scl_i && $rose(sda_i) |-> ##[1:6] !busy_o)
		else $error("stop not seen");
	chk_wr_pulse: assert property (wr_en_o |=> !wr_en_o)
		else $error("write strobe too long");
	chk_rd_pulse: assert property (rd_done_o |=> !rd_done_o)
		else $error("read strobe too long");
	chk_wr_frame: assert property (wr_en_o |-> busy_o)
		else $error("write outside frame");
	chk_ring_step: assert property (wr_en_o && wr_addr_o[7:2] == 6'h04
		|-> ##[1:4] rd_addr_o == {6'h04, wr_addr_o[1:0] + 2'h1})
		else $error("ring pointer did not step");
	chk_single_hold: assert property (wr_en_o && wr_addr_o[7:4] == 4'h0
		|-> ##[1:4] rd_addr_o == wr_addr_o)
		else $error("single pointer moved");
	cover property (wr_en_o && wr_addr_o == 8'h13);
	cover property (rd_done_o);
	cover property ($rose(sda_oe_o));
endmodule // slave_monitor

bind i2c_strap_slave slave_monitor u_mon (.mclk_i(mclk_i), .nrst_i(nrst_i), .scl_i(scl_i),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wr_en_o(wr_en_o),
	.wr_addr_o(wr_addr_o), .rd_addr_o(rd_addr_o), .rd_done_o(rd_done_o), .busy_o(busy_o));

/* verif/test_i2c_slave_port_with_strap_addressing.sv */
`timescale 1ns/1ps
module test_i2c_slave_port_with_strap_addressing;
	reg mclk_i = 1'b0;
	reg nrst_i = 1'b0;
	reg [5:0] cls = 6'h15;
	integer bad_count = 0;
	integer checks = 0;
	integer cyc = 0;
	integer rd_cnt = 0;
	reg [15:0] wq [$];
	wire scl_w, pull_w, sda_o, sda_oe_o, wr_en_o, rd_done_o, busy_o;
	wire [7:0] wr_addr_o, wr_data_o, rd_addr_o;
	wire [6:0] dev_addr_o;
	wire [2:0] pin_w;
	// Pull-up: low only while someone pulls
	wire sda_w = ~(pull_w | sda_oe_o);
	wire [7:0] rd_data_w = rd_addr_o ^ 8'h5a;
	genvar k;
	generate for (k = 0; k < 3; k = k + 1) begin : g_pin
		assign pin_w[k] = cls[2*k+1] ? (cls[2*k] ? sda_w : scl_w) : cls[2*k];
	end endgenerate
	i2c_strap_slave DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .scl_i(scl_w), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_select_pin_0_i(pin_w[0]),
		.addr_select_pin_1_i(pin_w[1]), .addr_select_pin_2_i(pin_w[2]),
		.wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
		.rd_addr_o(rd_addr_o), .rd_data_i(rd_data_w), .rd_done_o(rd_done_o),
		.busy_o(busy_o), .dev_addr_o(dev_addr_o));
	bus_ctrl u_ctrl (.clk_i(mclk_i), .sda_i(sda_w), .scl_o(scl_w), .pull_o(pull_w));
	initial forever #50 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		if (wr_en_o === 1'b1) wq.push_back({wr_addr_o, wr_data_o});
		if (rd_done_o === 1'b1) rd_cnt = rd_cnt + 1;
		cyc = cyc + 1;
		if (cyc == 20000) begin
			bad_count = bad_count + 1;
			print_verdict;
		end
	end
	function [6:0] exp_addr(input [5:0] c);
		exp_addr = {c[5], c[3] ? 2'b01 : 2'b10, c[1], c[4], c[2], c[0]};
	endfunction
	task print_verdict;
		$display("bad_count %0d checks %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input [15:0] seen, input [15:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task expq(input integer n, input [47:0] e);
		integer i;
		chk(wq.size(), n);
		for (i = 0; i < n; i = i + 1) chk(wq[i], e[47-16*i -: 16]);
		wq.delete();
	endtask
	task wr(input [6:0] a, input exp_ack, input integer n, input [31:0] b);
		reg ack;
		integer i;
		u_ctrl.start;
		u_ctrl.wb({a, 1'b0}, ack);
		chk(ack, exp_ack);
		for (i = 0; i < n; i = i + 1) begin
			u_ctrl.wb(b[31-8*i -: 8], ack);
			chk(ack, exp_ack);
		end
		u_ctrl.stop;
	endtask
	task t_strap;
		integer i;
		for (i = 0; i < 6; i = i + 1) begin
			cls = 36'h215bb3af4 >> (30 - 6 * i);
			wr(exp_addr(cls), 1'b1, 0, 32'h0);
			chk(dev_addr_o, exp_addr(cls));
		end
	endtask
	task t_write;
		wr(exp_addr(cls), 1'b1, 4, 32'h12a1b2c3);
		expq(3, 48'h12a1_13b2_10c3);
		chk(busy_o, 16'h0);
	endtask
	task t_cmd;
		wr(exp_addr(cls), 1'b1, 1, 32'h03000000);
		expq(0, 48'h0);
		chk(rd_addr_o, 8'h03);
		wr(exp_addr(cls), 1'b1, 3, 32'h03556600);
		expq(2, 48'h0355_0366_0000);
	endtask
	task t_miss;
		wr(exp_addr(cls) ^ 7'h01, 1'b0, 2, 32'h10770000);
		expq(0, 48'h0);
	endtask
	task t_read;
		reg ack;
		reg [7:0] d;
		integer n0;
		wr(exp_addr(cls), 1'b1, 1, 32'h13000000);
		n0 = rd_cnt;
		u_ctrl.start;
		u_ctrl.wb({exp_addr(cls), 1'b1}, ack);
		chk(ack, 1'b1);
		u_ctrl.rb(1'b0, d);
		chk(d, 8'h49);
		u_ctrl.rb(1'b1, d);
		chk(d, 8'h4a);
		u_ctrl.stop;
		chk(rd_addr_o, 8'h11);
		chk(rd_cnt - n0, 2);
	endtask
	initial begin
		repeat (3) @(posedge mclk_i);
		#1 nrst_i = 1'b1;
		u_ctrl.wt(6);
		t_strap;
		t_write;
		t_cmd;
		t_miss;
		t_read;
		print_verdict;
	end
endmodule // test_i2c_slave_port_with_strap_addressing
